// ### ebt_counter.sv
// 8-bit up counter with comparator, match/overflow event detection and output pin logic.
// Assumes ticks come from the divider on the same clock.
`default_nettype none

module ebt_counter #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Settings and tick
	ebt_tick_if.user              tk,
	input  wire logic             run,
	input  wire logic             interval,
	input  wire logic [2:0]       prescale,
	input  wire logic             clear,
	input  wire logic [WIDTH-1:0] reference,
	// Results
	output logic [WIDTH-1:0]      count,
	output logic                  match_evt,
	output logic                  ovf_evt,
	output logic                  pin_out
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             toggle;
		logic             pwm;
		logic             match;
		logic             ovf;
	} ebt_cnt_state_t;

	ebt_cnt_state_t state_reg;
	ebt_cnt_state_t state_next;

	assign tk.run        = run;
	assign tk.interval   = interval;
	assign tk.prescale   = prescale;
	assign tk.sync_clear = clear;
	assign count         = state_reg.count;
	assign match_evt     = state_reg.match;
	assign ovf_evt       = state_reg.ovf;
	assign pin_out       = interval ? state_reg.toggle : state_reg.pwm;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next       = state_reg;
		state_next.match = 1'b0;
		state_next.ovf   = 1'b0;
		if (clear) begin
			state_next.count = '0;
		end else if (tk.tick) begin
			if (state_reg.count == reference) begin
				state_next.match = 1'b1;
				if (interval) begin
					state_next.count  = '0;
					state_next.toggle = !state_reg.toggle;
				end else begin
					state_next.count = state_reg.count + 1'b1;
				end
			end else begin
				state_next.count = state_reg.count + 1'b1;
			end
			if (!interval && state_reg.count == '1) begin
				state_next.ovf = 1'b1;
			end
		end
		// Registered from the next count so the pin changes cleanly on the same clock as the count.
		state_next.pwm = reference > state_next.count;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule // ebt_counter

`default_nettype wire

// ### ebt_divider.sv
// Source divider (1 or 64) followed by the 3-bit prescaler (1 to 8).
// Assumes run, mode and prescale are registered settings from the same clock.
`default_nettype none

module ebt_divider (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Tick link
	ebt_tick_if.divider tk
);

	typedef struct packed {
		logic [5:0] src_cnt;
		logic [2:0] pre_cnt;
	} ebt_div_state_t;

	ebt_div_state_t state_reg;
	ebt_div_state_t state_next;
	logic           src_tick;

	////////////////////////////////////////////////////////////////////////////////
	// The source tick is every clock in PWM mode, every 64th in interval mode.
	always_comb begin
		state_next = state_reg;
		src_tick   = 1'b0;
		tk.tick    = 1'b0;
		if (!tk.run || tk.sync_clear) begin
			// Restarting the divider on a clear keeps the first interval exact.
			state_next = '0;
		end else begin
			if (!tk.interval) begin
				src_tick = 1'b1;
			end else if (state_reg.src_cnt == ebt_pkg::INTERVAL_DIV_LAST) begin
				src_tick           = 1'b1;
				state_next.src_cnt = '0;
			end else begin
				state_next.src_cnt = state_reg.src_cnt + 6'h01;
			end
			if (src_tick) begin
				if (state_reg.pre_cnt >= tk.prescale) begin
					tk.tick            = 1'b1;
					state_next.pre_cnt = '0;
				end else begin
					state_next.pre_cnt = state_reg.pre_cnt + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule // ebt_divider

`default_nettype wire

// ### ebt_irq_model.sv
// Model of the CPU interrupt logic that receives the timer request.
// Assumes the request is a level on the system clock.
`default_nettype none
module ebt_irq_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Request from the timer
	input  wire logic       request,
	input  wire logic [1:0] level,
	input  wire logic [7:0] vector,
	// Set once a request was taken
	output logic            seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// A request on any other level or vector is ignored, as the real controller would.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			seen <= 1'b0;
		end else if (request && level == 2'h2 && vector == 8'hd4) begin
			seen <= 1'b1;
		end
	end
endmodule // ebt_irq_model
`default_nettype wire

// ### ebt_pkg.sv
// Package for the 8-bit interval/PWM timer: register map, field layout, reset values.
// Assumes a single 10 MHz system clock and the CPU register port of the top module.
`default_nettype none

package ebt_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register addresses on the CPU register port.
	localparam logic [7:0] TIMER_CONTROL_ADDR = 8'hec;
	localparam logic [7:0] COMPARE_REF_ADDR   = 8'hed;
	localparam logic [7:0] COUNT_VALUE_ADDR   = 8'hee;

	// Interrupt level and vector of the match/overflow request.
	localparam int         IRQ_LEVEL  = 2;
	localparam logic [7:0] IRQ_VECTOR = 8'hd4;

	// Control register field positions.
	localparam int CTL_RUN_BIT     = 7;
	localparam int CTL_PRE_HI      = 6;
	localparam int CTL_PRE_LO      = 4;
	localparam int CTL_CLEAR_BIT   = 3;
	localparam int CTL_MODE_BIT    = 2;
	localparam int CTL_IRQ_EN_BIT  = 1;
	localparam int CTL_PENDING_BIT = 0;

	// Reset values.
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] REF_RESET     = 8'hff;
	localparam logic [7:0] COUNT_RESET   = 8'h00;

	// Source clock division in interval mode.
	localparam int         INTERVAL_DIV = 64;
	localparam logic [5:0] INTERVAL_DIV_LAST = 6'(INTERVAL_DIV - 1);

	typedef enum logic {
		EBT_MODE_PWM,
		EBT_MODE_INTERVAL
	} ebt_mode_t;

endpackage : ebt_pkg

`default_nettype wire

// ### ebt_tick_if.sv
// Interface carrying the count tick from the divider to the counter and its settings from the counter to the divider.
// Assumes both ends run on the same system clock.
`default_nettype none

interface ebt_tick_if;
	logic                run;
	logic                interval;
	logic [2:0]          prescale;
	logic                sync_clear;
	logic                tick;

	modport divider (input run, input interval, input prescale, input sync_clear, output tick);
	modport user    (output run, output interval, output prescale, output sync_clear,
		input tick);
endinterface : ebt_tick_if

`default_nettype wire

// ### ebt_timer.sv
// Top of the 8-bit interval/PWM timer: CPU register port, control register, pending flag.
// Assumes a synchronous single-cycle register port on the system clock; the CPU
// interrupt logic samples the request level.
`default_nettype none

//
// Contract
// - Interval mode toggles pin; match interrupt only.
// - PWM mode; match and overflow request interrupt.
// - 8-bit counter, comparator and reference register.
// - One shared request, level two, one vector.
// - PWM match never resets the counter.
// - Control at ECh, reset to zero.
// - Bit 3 clears counter, self-clears.
// - Bit 7 starts or halts counting.
// - Bits 6:4 prescale by field plus one.
// - Bit 2 picks clock source and mode.
// - Bit 1 gates the interrupt request.
// - Bit 0 pending; write zero clears.
// - Pending sets even while interrupt disabled.
module ebt_timer #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// CPU register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic             reg_wr,
	input  wire logic [7:0]       reg_wdata,
	output logic [7:0]            reg_rdata,
	// Interrupt to the CPU interrupt logic
	output logic                  match_overflow_request,
	output logic [1:0]            interrupt_level_two,
	output logic [7:0]            irq_vector,
	// Output pin
	output logic                  toggle_or_pulse_output
);

	typedef struct packed {
		logic             run;
		logic [2:0]       prescale;
		logic             clear;
		logic             mode;
		logic             irq_en;
		logic             pending;
		logic [WIDTH-1:0] reference;
		logic [7:0]       rdata;
	} ebt_top_state_t;

	ebt_top_state_t   state_reg;
	ebt_top_state_t   state_next;
	logic [WIDTH-1:0] count_value;
	logic             match_evt;
	logic             ovf_evt;
	logic             pin_out;
	logic             ctl_wr;
	logic [7:0]       control;

	ebt_tick_if tick_link ();

	////////////////////////////////////////////////////////////////////////////////
	ebt_divider u_divider (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tk      (tick_link.divider)
	);

	ebt_counter #(
		.WIDTH (WIDTH)
	) u_counter (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.tk        (tick_link.user),
		.run       (state_reg.run),
		.interval  (state_reg.mode),
		.prescale  (state_reg.prescale),
		.clear     (state_reg.clear),
		.reference (state_reg.reference),
		.count     (count_value),
		.match_evt (match_evt),
		.ovf_evt   (ovf_evt),
		.pin_out   (pin_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	assign ctl_wr = reg_wr && (reg_addr == ebt_pkg::TIMER_CONTROL_ADDR);

	always_comb begin
		control = '0;
		control[ebt_pkg::CTL_RUN_BIT]                     = state_reg.run;
		control[ebt_pkg::CTL_PRE_HI:ebt_pkg::CTL_PRE_LO]  = state_reg.prescale;
		control[ebt_pkg::CTL_CLEAR_BIT]                   = state_reg.clear;
		control[ebt_pkg::CTL_MODE_BIT]                    = state_reg.mode;
		control[ebt_pkg::CTL_IRQ_EN_BIT]                  = state_reg.irq_en;
		control[ebt_pkg::CTL_PENDING_BIT]                 = state_reg.pending;
	end

	always_comb begin
		state_next       = state_reg;
		// The clear bit lives for exactly one cycle, the cycle the counter is cleared.
		state_next.clear = 1'b0;
		if (ctl_wr) begin
			state_next.run      = reg_wdata[ebt_pkg::CTL_RUN_BIT];
			state_next.prescale = reg_wdata[ebt_pkg::CTL_PRE_HI:ebt_pkg::CTL_PRE_LO];
			state_next.clear    = reg_wdata[ebt_pkg::CTL_CLEAR_BIT];
			state_next.mode     = reg_wdata[ebt_pkg::CTL_MODE_BIT];
			state_next.irq_en   = reg_wdata[ebt_pkg::CTL_IRQ_EN_BIT];
			if (!reg_wdata[ebt_pkg::CTL_PENDING_BIT]) begin
				state_next.pending = 1'b0;
			end
		end
		if (reg_wr && reg_addr == ebt_pkg::COMPARE_REF_ADDR) begin
			state_next.reference = reg_wdata[WIDTH-1:0];
		end
		// An event in the clearing cycle wins, so no event is lost.
		if (match_evt || (ovf_evt && !state_reg.mode)) begin
			state_next.pending = 1'b1;
		end
		case (reg_addr)
			ebt_pkg::TIMER_CONTROL_ADDR: state_next.rdata = control;
			ebt_pkg::COMPARE_REF_ADDR:   state_next.rdata = 8'(state_reg.reference);
			ebt_pkg::COUNT_VALUE_ADDR:   state_next.rdata = 8'(count_value);
			default:                     state_next.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg           <= '0;
			state_reg.reference <= WIDTH'(ebt_pkg::REF_RESET);
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign reg_rdata              = state_reg.rdata;
	assign match_overflow_request = state_reg.pending && state_reg.irq_en;
	assign interrupt_level_two    = 2'(ebt_pkg::IRQ_LEVEL);
	assign irq_vector             = ebt_pkg::IRQ_VECTOR;
	assign toggle_or_pulse_output = pin_out;

endmodule // ebt_timer

`default_nettype wire

// ### ebt_timer_properties.sv
// Port-level checks of the timer; bound to every ebt_timer instance.
// Assumes the one-cycle registered read port described for the top module.
`default_nettype none
module ebt_timer_properties (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       match_overflow_request,
	input wire logic [1:0] interrupt_level_two,
	input wire logic [7:0] irq_vector,
	input wire logic       toggle_or_pulse_output
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	property p_level; interrupt_level_two == 2'h2; endproperty
	a_level: assert property (p_level) else $error("level not two");
	property p_vector; irq_vector == 8'hd4; endproperty
	a_vector: assert property (p_vector) else $error("vector changed");
	property p_fell; $fell(sys_rst) |-> !match_overflow_request && reg_rdata == 8'h00; endproperty
	a_fell: assert property (p_fell) else $error("state after reset");
	property p_gate; reg_wr && reg_addr == 8'hec && !reg_wdata[1] |=> !match_overflow_request;
	endproperty
	a_gate: assert property (p_gate) else $error("request not gated");
	property p_bit3; (reg_wr && reg_addr == 8'hec && reg_wdata[3])
		##1 (!reg_wr && reg_addr == 8'hec)[*3] |-> !reg_rdata[3]; endproperty
	a_bit3: assert property (p_bit3) else $error("clear bit stuck");
	property p_halt; (reg_wr && reg_addr == 8'hec && !reg_wdata[7])
		##1 (!reg_wr && $stable(reg_addr))[*4] |-> $stable(reg_rdata); endproperty
	a_halt: assert property (p_halt) else $error("moved while halted");
	property p_pin_halt; (reg_wr && reg_addr == 8'hec && reg_wdata[7:2] == 6'h01)
		##1 !reg_wr[*4] |-> $stable(toggle_or_pulse_output); endproperty
	a_pin_halt: assert property (p_pin_halt) else $error("pin moved while halted");
	property p_count; (reg_wr && reg_addr == 8'hec && (reg_wdata & 8'hf4) == 8'h80)
		##1 (!reg_wr && reg_addr == 8'hee)[*5] |-> reg_rdata == $past(reg_rdata) + 8'h01;
	endproperty
	a_count: assert property (p_count) else $error("count step");
	cover property (match_overflow_request);
	cover property ($changed(toggle_or_pulse_output));
	cover property (reg_wr && reg_addr == 8'hec && reg_wdata[3]);
endmodule // ebt_timer_properties

bind ebt_timer ebt_timer_properties u_ebt_timer_properties (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.match_overflow_request(match_overflow_request), .interrupt_level_two(interrupt_level_two),
	.irq_vector(irq_vector), .toggle_or_pulse_output(toggle_or_pulse_output));
`default_nettype wire

// ### test_eight_bit_interval_pwm_timer.sv
// Self-checking bench of the timer with the interrupt model on its request.
// Assumes the design, checker and model files are compiled first.
`default_nettype none
module test_eight_bit_interval_pwm_timer;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, sys_rst, we, req, pin, seen;
	logic [7:0]  addr, wd, rdata, vec, v;
	logic [1:0]  lvl;
	logic [31:0] rs = 32'h326c;
	int          n_errors, samples_checked, cyc, t, k;
	ebt_timer u_ebt_timer (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wr(we),
		.reg_wdata(wd), .reg_rdata(rdata), .match_overflow_request(req),
		.interrupt_level_two(lvl), .irq_vector(vec), .toggle_or_pulse_output(pin));
	ebt_irq_model u_ebt_irq_model (.clk(clk), .sys_rst(sys_rst), .request(req),
		.level(lvl), .vector(vec), .seen(seen));
	////////////////////////////////////////
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction
	function automatic logic [15:0] per(int m, int p);
		return 16'((m ? 64 : 1) * (p + 1));
	endfunction
	task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp);
		samples_checked++;
		if (seen_v !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen_v, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] dv);
		@(posedge clk);
		addr <= a;
		wd <= dv;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		@(negedge clk) q = rdata;
	endtask
	// Cycles between two successive changes of the pin or of the read data.
	task automatic gap(input bit sp, output int n);
		logic [7:0] o;
		// A control write with the clear bit makes one or two transient changes of the read
		// data; letting them pass first means only tick-to-tick gaps are measured.
		repeat (3) @(posedge clk);
		@(negedge clk) o = sp ? {7'h0, pin} : rdata;
		repeat (2) begin
			n = 0;
			do @(negedge clk) n++; while ((sp ? {7'h0, pin} : rdata) === o && n < 1200);
			o = sp ? {7'h0, pin} : rdata;
		end
	endtask
	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// The whole run needs about 6000 cycles.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		sys_rst = 1'b1;
		we = 1'b0;
		addr = 8'h00;
		wd = 8'h00;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'hec, v);
		chk(v, 8'h00);
		rd(8'hed, v);
		chk(v, 8'hff);
		rd(rnd() & 8'h7f, v);
		chk(v, 8'h00);
		chk(vec, 8'hd4);
		chk(lvl, 2'h2);
		$display("test reset done");
		for (k = 0; k < 16; k++) begin
			wr(8'hec, 8'h88 | 8'((k % 8) << 4) | 8'((k / 8) << 2));
			addr <= 8'hee;
			gap(0, t);
			chk(16'(t), per(k / 8, k % 8));
		end
		$display("test prescale done");
		k = rnd() % 200 + 20;
		wr(8'hed, 8'(k));
		wr(8'hec, 8'h8a);
		gap(1, t);
		chk(16'(t), pin ? 16'(256 - k) : 16'(k));
		chk(seen, 1'b1);
		wr(8'hec, 8'h8a);
		rd(8'hee, v);
		chk(v, 8'h00);
		$display("test pwm done");
		k = rnd() % 8 + 2;
		wr(8'hed, 8'(k));
		wr(8'hec, 8'h8c);
		gap(1, t);
		// One toggle per reference-plus-one ticks of 64 clocks each.
		chk(16'(t), 16'(per(1, 0) * (k + 1)));
		wr(8'hec, 8'h05);
		// Idle cycles so the halt checks see the stopped timer.
		repeat (4) @(posedge clk);
		rd(8'hec, v);
		chk(v, 8'h05);
		chk(req, 1'b0);
		wr(8'hec, 8'h07);
		repeat (20) @(posedge clk);
		rd(8'hec, v);
		chk(v, 8'h07);
		chk(req, 1'b1);
		wr(8'hec, 8'h06);
		rd(8'hec, v);
		chk(v, 8'h06);
		chk(req, 1'b0);
		$display("test interval done");
		conclude();
	end
endmodule // test_eight_bit_interval_pwm_timer
`default_nettype wire
